// ===== hw/scmc_pkg.sv
package scmc_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam int SCMC_AW = 4;
  localparam int SCMC_DW = 16;
  localparam logic [3:0] SCMC_PROTECT_ADDR = 4'h0;
  localparam logic [3:0] SCMC_SCLK_ADDR = 4'h1;
  localparam logic [3:0] SCMC_OSC_ADDR = 4'h2;
  localparam logic [3:0] SCMC_STOPDET_ADDR = 4'h3;
  localparam logic [3:0] SCMC_FLAG_ADDR = 4'h4;
  localparam logic [3:0] SCMC_IEN_ADDR = 4'h5;
  localparam logic [3:0] SCMC_MODE_ADDR = 4'h6;
  localparam logic [15:0] SCMC_PROTECT_KEY = 16'h0096;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCMC_WAKE_EN_BIT = 15;
  localparam int SCMC_WDIV_LSB = 12;
  localparam int SCMC_WSRC_LSB = 8;
  localparam int SCMC_DIV_LSB = 4;
  localparam int SCMC_SRC_LSB = 0;
  localparam int SCMC_SLPC_LSB = 8;
  localparam int SCMC_EN_LSB = 0;
  localparam int SCMC_RESTART_BIT = 14;
  localparam int SCMC_DETECT_BIT = 13;
  localparam int SCMC_STOP_FLAG = 5;
  localparam int SCMC_TRIM_FLAG = 4;
  localparam int SCMC_HS_FLAG = 2;
  localparam int SCMC_LS_FLAG = 1;
  localparam int SCMC_INT_FLAG = 0;
  localparam int SCMC_MODE_SRC_LSB = 4;
  localparam int SCMC_MODE_SHIFT_LSB = 8;
  localparam logic [5:0] SCMC_FLAG_MASK = 6'h37;

  // ----------------------------------------------------------------
  // Source codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SCMC_SRC_INT = 2'h0;
  localparam logic [1:0] SCMC_SRC_LOW = 2'h1;
  localparam logic [1:0] SCMC_SRC_HIGH = 2'h2;
  localparam logic [1:0] SCMC_SRC_EXT = 2'h3;
  localparam logic [3:0] SCMC_EN_RST = 4'h1;
  localparam logic [3:0] SCMC_SLPC_RST = 4'hF;
  localparam logic [1:0] SCMC_SEL_RST = 2'h0;
  localparam logic SCMC_RESTART_RST = 1'b1;
  localparam logic SCMC_DETECT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCMC_RUN, SCMC_HALT, SCMC_SLEEP, SCMC_DEBUG
  } scmc_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } scmc_req_s;

  typedef struct packed {
    logic halt_exec;
    logic sleep_exec;
    logic periph_irq;
    logic wdt_nmi;
    logic dbg_irq;
    logic reset_req;
    logic retd_exec;
  } scmc_event_s;

  typedef struct packed {
    logic protect_open;
    logic wake_en;
    logic [1:0] wake_div;
    logic [1:0] wake_src;
    logic [1:0] act_div;
    logic [1:0] act_src;
    logic [3:0] slpc;
    logic [3:0] src_en;
    logic restart_en;
    logic detect_en;
    logic [5:0] flags;
    logic [5:0] ien;
    scmc_mode_e mode;
    logic [1:0] run_src;
    logic [2:0] run_shift;
    logic [3:0] osc_run;
    logic [3:0] stable_q;
    logic stop_q;
    logic restart_pulse;
    logic cpu_stop;
    logic irq;
    logic [15:0] rdata;
  } scmc_state_s;

endpackage

// ===== hw/scmc_top.sv
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module scmc_top
  import scmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire scmc_req_s req,
  output logic [15:0] rdata,
  // CPU events
  input wire scmc_event_s cpu_evt,
  // Oscillator status: stable levels, stop detector, trim done pulse
  input wire logic [3:0] osc_stable,
  input wire logic low_stop_det,
  input wire logic trim_done,
  // Clock controls
  output logic [3:0] osc_run,
  output logic low_restart,
  output logic [1:0] sys_src,
  output logic [2:0] sys_div_shift,
  // Mode and interrupt
  output scmc_mode_e mode,
  output logic cpu_stop,
  output logic irq
);

  // ----------------------------------------------------------------
  // Divider decode
  // ----------------------------------------------------------------
  // Ratio as a power of two; reserved combinations fall back to 1/1
  function automatic logic [2:0] div_shift(input logic [1:0] src,
                                           input logic [1:0] div);
    logic [2:0] s;
    s = 3'h0;
    case (src)
      SCMC_SRC_INT: s = {1'b0, div};
      SCMC_SRC_HIGH: begin
        if (div[1]) begin
          s = {1'b0, div} + 3'h1;
        end else begin
          s = {1'b0, div};
        end
      end
      SCMC_SRC_LOW: s = (div == 2'h1) ? 3'h1 : 3'h0;
      default: s = 3'h0;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  scmc_state_s st_ff;
  scmc_state_s nxt_st;

  logic wr_sclk;
  logic wr_osc;
  logic wr_stopdet;
  logic wr_flag;
  logic wr_ien;
  logic wake_evt;
  logic waking;
  logic stop_evt;
  logic [5:0] set_flags;
  logic [3:0] stable_rise;
  logic [3:0] sleep_keep;
  logic [3:0] src_onehot;

  // Decode strokes; protected targets also need the open key
  assign wr_sclk = req.wr && req.addr == SCMC_SCLK_ADDR
                   && st_ff.protect_open;
  assign wr_stopdet = req.wr && req.addr == SCMC_STOPDET_ADDR
                      && st_ff.protect_open;
  assign wr_osc = req.wr && req.addr == SCMC_OSC_ADDR;
  assign wr_flag = req.wr && req.addr == SCMC_FLAG_ADDR;
  assign wr_ien = req.wr && req.addr == SCMC_IEN_ADDR;

  // Any cancel source ends HALT or SLEEP, accepted or not
  assign wake_evt = cpu_evt.periph_irq || cpu_evt.wdt_nmi
                    || cpu_evt.dbg_irq || cpu_evt.reset_req;
  assign waking = st_ff.mode == SCMC_SLEEP && wake_evt;
  assign stable_rise = osc_stable & ~st_ff.stable_q & st_ff.osc_run;
  assign stop_evt = low_stop_det && !st_ff.stop_q && st_ff.detect_en;
  assign sleep_keep = st_ff.src_en & ~st_ff.slpc;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    src_onehot = 4'h0;
    set_flags = 6'h0;

    // Key register: only the exact key opens the protected fields
    if (req.wr && req.addr == SCMC_PROTECT_ADDR) begin
      nxt_st.protect_open = req.wdata == SCMC_PROTECT_KEY;
    end

    // System clock select register
    if (wr_sclk) begin
      nxt_st.wake_en = req.wdata[SCMC_WAKE_EN_BIT];
      nxt_st.wake_div = req.wdata[SCMC_WDIV_LSB +: 2];
      nxt_st.wake_src = req.wdata[SCMC_WSRC_LSB +: 2];
      nxt_st.act_div = req.wdata[SCMC_DIV_LSB +: 2];
      nxt_st.act_src = req.wdata[SCMC_SRC_LSB +: 2];
    end

    // Oscillator enable and stop-in-sleep register
    if (wr_osc) begin
      nxt_st.slpc = req.wdata[SCMC_SLPC_LSB +: 4];
      nxt_st.src_en = req.wdata[SCMC_EN_LSB +: 4];
      if (st_ff.src_en[SCMC_SRC_LOW] && !req.wdata[SCMC_SRC_LOW]) begin
        set_flags[SCMC_STOP_FLAG] = 1'b1;
      end
    end

    // Stop supervision register
    if (wr_stopdet) begin
      nxt_st.restart_en = req.wdata[SCMC_RESTART_BIT];
      nxt_st.detect_en = req.wdata[SCMC_DETECT_BIT];
      if (st_ff.detect_en && !req.wdata[SCMC_DETECT_BIT]) begin
        set_flags[SCMC_STOP_FLAG] = 1'b1;
      end
    end

    // A selected source must run, so selecting one starts it
    src_onehot[nxt_st.act_src] = 1'b1;
    nxt_st.src_en = nxt_st.src_en | src_onehot;

    if (wr_ien) begin
      nxt_st.ien = req.wdata[5:0] & SCMC_FLAG_MASK;
    end

    // Operating mode; debug entry outranks every other event
    case (st_ff.mode)
      SCMC_RUN: begin
        if (cpu_evt.dbg_irq) begin
          nxt_st.mode = SCMC_DEBUG;
        end else if (cpu_evt.sleep_exec) begin
          nxt_st.mode = SCMC_SLEEP;
        end else if (cpu_evt.halt_exec) begin
          nxt_st.mode = SCMC_HALT;
        end
      end
      SCMC_HALT, SCMC_SLEEP: begin
        if (cpu_evt.dbg_irq) begin
          nxt_st.mode = SCMC_DEBUG;
        end else if (wake_evt) begin
          nxt_st.mode = SCMC_RUN;
        end
      end
      SCMC_DEBUG: begin
        if (cpu_evt.retd_exec) begin
          nxt_st.mode = SCMC_RUN;
        end
      end
      default: nxt_st.mode = SCMC_RUN;
    endcase

    // Stop line is registered so the CPU never sees a decode glitch
    nxt_st.cpu_stop = nxt_st.mode != SCMC_RUN;

    // Wake switching overrides software writes in the same cycle
    if (waking && st_ff.wake_en) begin
      nxt_st.act_src = st_ff.wake_src;
      nxt_st.act_div = st_ff.wake_div;
      src_onehot = 4'h0;
      src_onehot[st_ff.wake_src] = 1'b1;
      nxt_st.src_en = sleep_keep | src_onehot;
    end

    // Stop detector edge; restart keeps the enable and pulses the core
    nxt_st.restart_pulse = stop_evt && st_ff.restart_en;
    if (stop_evt) begin
      set_flags[SCMC_STOP_FLAG] = 1'b1;
    end
    set_flags[SCMC_INT_FLAG] = stable_rise[SCMC_SRC_INT];
    set_flags[SCMC_LS_FLAG] = stable_rise[SCMC_SRC_LOW];
    set_flags[SCMC_HS_FLAG] = stable_rise[SCMC_SRC_HIGH];
    set_flags[SCMC_TRIM_FLAG] = trim_done;

    // Write-one clears, but a same-cycle set wins
    nxt_st.flags = st_ff.flags;
    if (wr_flag) begin
      nxt_st.flags = st_ff.flags & ~req.wdata[5:0];
    end
    nxt_st.flags = (nxt_st.flags | set_flags) & SCMC_FLAG_MASK;
    nxt_st.irq = |(nxt_st.flags & nxt_st.ien);

    // Sleep gates only sources marked stop-in-sleep; halt gates none
    if (nxt_st.mode == SCMC_SLEEP) begin
      nxt_st.osc_run = nxt_st.src_en & ~nxt_st.slpc;
    end else begin
      nxt_st.osc_run = nxt_st.src_en;
    end

    // Switch only onto a running, stable source to avoid runt pulses
    if (st_ff.osc_run[st_ff.act_src] && osc_stable[st_ff.act_src]) begin
      nxt_st.run_src = st_ff.act_src;
      nxt_st.run_shift = div_shift(st_ff.act_src, st_ff.act_div);
    end

    nxt_st.stable_q = osc_stable;
    nxt_st.stop_q = low_stop_det;

    // Read data, held for exactly the cycle after the strobe
    nxt_st.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        SCMC_SCLK_ADDR: begin
          nxt_st.rdata[SCMC_WAKE_EN_BIT] = st_ff.wake_en;
          nxt_st.rdata[SCMC_WDIV_LSB +: 2] = st_ff.wake_div;
          nxt_st.rdata[SCMC_WSRC_LSB +: 2] = st_ff.wake_src;
          nxt_st.rdata[SCMC_DIV_LSB +: 2] = st_ff.act_div;
          nxt_st.rdata[SCMC_SRC_LSB +: 2] = st_ff.act_src;
        end
        SCMC_OSC_ADDR: begin
          nxt_st.rdata[SCMC_SLPC_LSB +: 4] = st_ff.slpc;
          nxt_st.rdata[SCMC_EN_LSB +: 4] = st_ff.src_en;
        end
        SCMC_STOPDET_ADDR: begin
          nxt_st.rdata[SCMC_RESTART_BIT] = st_ff.restart_en;
          nxt_st.rdata[SCMC_DETECT_BIT] = st_ff.detect_en;
        end
        SCMC_FLAG_ADDR: nxt_st.rdata[5:0] = st_ff.flags;
        SCMC_IEN_ADDR: nxt_st.rdata[5:0] = st_ff.ien;
        SCMC_MODE_ADDR: begin
          nxt_st.rdata[1:0] = st_ff.mode;
          nxt_st.rdata[SCMC_MODE_SRC_LSB +: 2] = st_ff.run_src;
          nxt_st.rdata[SCMC_MODE_SHIFT_LSB +: 3] = st_ff.run_shift;
        end
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset boots in RUN on the internal oscillator
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.mode <= SCMC_RUN;
      st_ff.act_src <= SCMC_SEL_RST;
      st_ff.act_div <= SCMC_SEL_RST;
      st_ff.wake_src <= SCMC_SEL_RST;
      st_ff.wake_div <= SCMC_SEL_RST;
      st_ff.run_src <= SCMC_SRC_INT;
      st_ff.slpc <= SCMC_SLPC_RST;
      st_ff.src_en <= SCMC_EN_RST;
      st_ff.osc_run <= SCMC_EN_RST;
      st_ff.restart_en <= SCMC_RESTART_RST;
      st_ff.detect_en <= SCMC_DETECT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register
  assign rdata = st_ff.rdata;
  assign osc_run = st_ff.osc_run;
  assign low_restart = st_ff.restart_pulse;
  assign sys_src = st_ff.run_src;
  assign sys_div_shift = st_ff.run_shift;
  assign mode = st_ff.mode;
  assign cpu_stop = st_ff.cpu_stop;
  assign irq = st_ff.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence locked_sclk_write;
    req.wr && req.addr == SCMC_SCLK_ADDR && !st_ff.protect_open;
  endsequence

  sequence sleep_wake_switch;
    st_ff.mode == SCMC_SLEEP && st_ff.wake_en && wake_evt;
  endsequence

  locked_write_a: assert property (locked_sclk_write |=>
    $stable(st_ff.act_src) && $stable(st_ff.wake_en))
    else $error("protected select changed while locked");

  restart_pulse_a: assert property (
    stop_evt && st_ff.restart_en |=> low_restart ##1 !low_restart)
    else $error("restart pulse missing or too long");

  stop_flag_a: assert property (
    wr_osc && st_ff.src_en[SCMC_SRC_LOW] && !req.wdata[SCMC_SRC_LOW]
    |=> st_ff.flags[SCMC_STOP_FLAG])
    else $error("stop flag not set on enable drop");

  stable_flag_a: assert property (
    stable_rise[SCMC_SRC_HIGH] |=> st_ff.flags[SCMC_HS_FLAG])
    else $error("stable flag not set");

  trim_flag_a: assert property (trim_done |=>
    st_ff.flags[SCMC_TRIM_FLAG])
    else $error("trim flag not set");

  irq_gate_a: assert property (
    irq == |(st_ff.flags & st_ff.ien))
    else $error("interrupt request disagrees with flags");

  halt_clocks_a: assert property (
    st_ff.mode == SCMC_HALT |-> osc_run == st_ff.src_en)
    else $error("clock source stopped in halt");

  sleep_gate_a: assert property (
    st_ff.mode == SCMC_SLEEP |-> (osc_run & st_ff.slpc) == 4'h0)
    else $error("stop-in-sleep source still running");

  wake_cancel_a: assert property (
    st_ff.mode == SCMC_HALT && cpu_evt.periph_irq && !cpu_evt.dbg_irq
    |=> mode == SCMC_RUN)
    else $error("halt not cancelled");

  wake_copy_a: assert property (sleep_wake_switch |=>
    st_ff.act_src == $past(st_ff.wake_src) && st_ff.src_en[st_ff.act_src])
    else $error("wake source not applied");

  switch_stable_a: assert property (
    !$stable(sys_src) |-> $past(osc_stable[st_ff.act_src]))
    else $error("clock switched onto unstable source");

  key_open_a: assert property (
    req.wr && req.addr == SCMC_PROTECT_ADDR
    |=> st_ff.protect_open == ($past(req.wdata) == SCMC_PROTECT_KEY))
    else $error("protection state does not follow the key");

  debug_entry_a: assert property (
    cpu_evt.dbg_irq && st_ff.mode != SCMC_DEBUG |=> mode == SCMC_DEBUG)
    else $error("debug interrupt did not enter debug mode");

  sleep_entry_a: assert property (
    st_ff.mode == SCMC_RUN && cpu_evt.sleep_exec && !cpu_evt.dbg_irq
    |=> mode == SCMC_SLEEP)
    else $error("sleep not entered");

  stop_line_a: assert property (
    cpu_stop == (mode != SCMC_RUN))
    else $error("cpu stop line disagrees with mode");

  wake_keep_a: assert property (sleep_wake_switch |=>
    st_ff.src_en == ($past(sleep_keep) | (4'h1 << $past(st_ff.wake_src))))
    else $error("wake enables not trimmed to kept sources");

  select_start_a: assert property (
    wr_sclk |=> st_ff.src_en[st_ff.act_src])
    else $error("selected source not started");

endmodule

// ===== sim/scmc_osc_model.sv
`timescale 1ns/1ps
module scmc_osc_model #(
  parameter int DLY = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Controls from the block
  input wire logic [3:0] osc_run,
  input wire logic low_restart,
  // Bench command that kills the low-speed oscillator
  input wire logic kill_low,
  // Status back to the block
  output logic [3:0] osc_stable,
  output logic low_stop_det
);
  logic [3:0] cnt_ff [4];
  logic dead_ff;

  // -------------------------------------------------------------
  // Start-up wait per source
  // -------------------------------------------------------------
  // A stopped or dead source restarts its wait, so stable always rises anew
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (rst || !osc_run[i] || (i == 1 && dead_ff)) begin
        cnt_ff[i] <= 4'h0;
      end else if (cnt_ff[i] != DLY[3:0]) begin
        cnt_ff[i] <= cnt_ff[i] + 4'h1;
      end
    end
    if (rst || low_restart) begin
      dead_ff <= 1'b0;
    end else if (kill_low) begin
      dead_ff <= 1'b1;
    end
  end

  // Stable level and stop detector output
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      osc_stable[i] = (cnt_ff[i] == DLY[3:0]);
    end
    low_stop_det = dead_ff;
  end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
  import scmc_pkg::*;
  localparam logic [3:0] PR = SCMC_PROTECT_ADDR;
  localparam logic [3:0] SC = SCMC_SCLK_ADDR;
  localparam logic [3:0] OS = SCMC_OSC_ADDR;
  localparam logic [3:0] SD = SCMC_STOPDET_ADDR;
  localparam logic [3:0] FL = SCMC_FLAG_ADDR;
  localparam logic [3:0] IE = SCMC_IEN_ADDR;
  logic clock, rst, kill, trim_done, low_stop_det, low_restart;
  logic cpu_stop, irq;
  scmc_req_s req;
  scmc_event_s cpu_evt;
  logic [15:0] rdata, v;
  logic [3:0] osc_stable, osc_run;
  logic [1:0] sys_src;
  logic [2:0] sys_div_shift;
  scmc_mode_e mode;
  int errors, checks, restarts, n;
  logic [6:0] n_evt [3] = '{7'h10, 7'h08, 7'h02};

  scmc_top dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
    .cpu_evt(cpu_evt), .osc_stable(osc_stable),
    .low_stop_det(low_stop_det), .trim_done(trim_done),
    .osc_run(osc_run), .low_restart(low_restart), .sys_src(sys_src),
    .sys_div_shift(sys_div_shift), .mode(mode), .cpu_stop(cpu_stop),
    .irq(irq));
  scmc_osc_model osc (.clock(clock), .rst(rst), .osc_run(osc_run),
    .low_restart(low_restart), .kill_low(kill), .osc_stable(osc_stable),
    .low_stop_det(low_stop_det));

  // -------------------------------------------------------------
  // Clock, restart counter and watchdog
  // -------------------------------------------------------------
  always #2.5 clock = ~clock;
  always @(posedge clock) if (low_restart === 1'b1) restarts++;
  initial begin
    #20000;
    errors++;
    stop_test();
  end

  // -------------------------------------------------------------
  // Access tasks
  // -------------------------------------------------------------
  task automatic chk(input string s, input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rchk(input string s, input logic [3:0] a, logic [15:0] e);
    rd(a);
    chk(s, v, e);
  endtask
  task automatic ev(input logic [6:0] e);
    @(posedge clock);
    cpu_evt <= e;
    @(posedge clock);
    cpu_evt <= '0;
    #1;
  endtask
  task automatic cm(input scmc_mode_e e);
    chk("mode", {14'h0, mode}, {14'h0, e});
    chk("cpu_stop", {15'h0, cpu_stop}, {15'h0, e != SCMC_RUN});
  endtask
  // Protected write: open with the key, write, close again
  task automatic pwr(input logic [3:0] a, input logic [15:0] d);
    wr(PR, SCMC_PROTECT_KEY);
    wr(a, d);
    wr(PR, 16'h0000);
  endtask
  task automatic wsrc(input logic [1:0] s, input logic [2:0] sh);
    for (n = 0; n < 100 && sys_src !== s; n++) tick();
    chk("sys_src", {14'h0, sys_src}, {14'h0, s});
    chk("shift", {13'h0, sys_div_shift}, {13'h0, sh});
  endtask
  task automatic stop_test;
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Tests
  // -------------------------------------------------------------
  initial begin
    clock = 0;
    rst = 1;
    kill = 0;
    trim_done = 0;
    req = '0;
    cpu_evt = '0;
    repeat (2) @(posedge clock);
    rst <= 0;
    rchk("flags", FL, 16'h0000);
    rchk("sclk", SC, 16'h0000);
    rchk("osc", OS, 16'h0F01);
    rchk("osc en", OS, 16'h0F01);
    rchk("stopdet", SD, 16'h4000);
    rchk("ien", IE, 16'h0000);
    rchk("unmapped", 4'h7, 16'h0000);
    chk("boot src", {14'h0, sys_src}, 16'h0000);
    cm(SCMC_RUN);
    wr(SC, 16'h0012);
    rchk("locked", SC, 16'h0000);
    pwr(SC, 16'h0012);
    wr(SC, 16'h0023);
    rchk("sclk wr", SC, 16'h0012);
    chk("start", {12'h0, osc_run}, 16'h0005);
    wsrc(SCMC_SRC_HIGH, 3'h1);
    rchk("status", SCMC_MODE_ADDR, 16'h0120);
    rchk("stable", FL, 16'h0005);
    wr(IE, 16'h0004);
    tick();
    chk("irq on", {15'h0, irq}, 16'h0001);
    wr(FL, 16'h0004);
    rchk("w1c", FL, 16'h0001);
    chk("irq off", {15'h0, irq}, 16'h0000);
    @(posedge clock) trim_done <= 1;
    @(posedge clock) trim_done <= 0;
    rchk("trim", FL, 16'h0011);
    wr(FL, 16'h0011);
    rchk("trim clr", FL, 16'h0000);
    // Halt keeps every source; three cancel sources each bring RUN back
    foreach (n_evt[i]) begin
      ev(7'h40);
      cm(SCMC_HALT);
      chk("halt run", {12'h0, osc_run}, 16'h0005);
      ev(n_evt[i]);
      cm(SCMC_RUN);
    end
    ev(7'h04);
    cm(SCMC_DEBUG);
    ev(7'h01);
    cm(SCMC_RUN);
    // Sleep keeps only the high-speed source; no wake switch first
    wr(OS, 16'h0B0D);
    ev(7'h20);
    cm(SCMC_SLEEP);
    chk("sleep run", {12'h0, osc_run}, 16'h0004);
    ev(7'h10);
    cm(SCMC_RUN);
    rchk("no switch", SC, 16'h0012);
    pwr(SC, 16'h9012);
    ev(7'h20);
    ev(7'h08);
    cm(SCMC_RUN);
    rchk("wake sclk", SC, 16'h9010);
    rchk("wake osc", OS, 16'h0B05);
    wsrc(SCMC_SRC_INT, 3'h1);
    // Stop supervision armed only once the low-speed clock is stable
    wr(OS, 16'h0B07);
    for (n = 0; n < 100 && osc_stable[1] !== 1'b1; n++) tick();
    pwr(SD, 16'h6000);
    wr(FL, 16'h0037);
    wr(IE, 16'h0020);
    @(posedge clock) kill <= 1;
    @(posedge clock) kill <= 0;
    rchk("stop", FL, 16'h0020);
    chk("restart", restarts[15:0], 16'h0001);
    chk("stop irq", {15'h0, irq}, 16'h0001);
    wr(FL, 16'h0020);
    pwr(SD, 16'h4000);
    rd(FL);
    chk("det off", v & 16'h0020, 16'h0020);
    wr(FL, 16'h0020);
    wr(OS, 16'h0B05);
    rd(FL);
    chk("en off", v & 16'h0020, 16'h0020);
    // High-speed at its deepest ratio, then the stopped low-speed source
    pwr(SC, 16'h0032);
    wsrc(SCMC_SRC_HIGH, 3'h4);
    pwr(SC, 16'h0011);
    wsrc(SCMC_SRC_LOW, 3'h1);
    stop_test();
  end
endmodule
